// >>> rtl/dtpb_defs.vh
// Register map, field positions and reset values for the dual timer block.
// Assumes an 8-bit register port and a single instruction clock.
`ifndef DTPB_DEFS_VH
`define DTPB_DEFS_VH

`define DTPB_AW 4
`define DTPB_DW 8
`define DTPB_ADDR_POWER_CTRL 4'h0
`define DTPB_ADDR_UP_MODE 4'h1
`define DTPB_ADDR_UP_COUNT 4'h2
`define DTPB_ADDR_IRQ_ENABLE 4'h3
`define DTPB_ADDR_IRQ_FLAG 4'h4
`define DTPB_ADDR_DN_CTRL_ONE 4'h5
`define DTPB_ADDR_DN_CTRL_TWO 4'h6
`define DTPB_ADDR_DN_COUNT 4'h7
`define DTPB_ADDR_PS1_VALUE 4'h8
`define DTPB_ADDR_PWM_DUTY 4'h9
`define DTPB_ADDR_BUZZ_CTRL 4'hA

`define DTPB_UP_EN_BIT 0
`define DTPB_GIE_BIT 7
`define DTPB_LOWCLK_BIT 7
`define DTPB_SRC_BIT 5
`define DTPB_EDGE_BIT 4
`define DTPB_PSA_BIT 3
`define DTPB_SECOND_PRESCALER_ENABLE_N_N_BIT 3
`define DTPB_RATIO_MSB 2
`define DTPB_UP_IRQ_BIT 0
`define DTPB_DN_IRQ_BIT 3
`define DTPB_DN_EN_BIT 0
`define DTPB_RELOAD_BIT 1
`define DTPB_ONESHOT_BIT 2
`define DTPB_PWM_AL_BIT 6
`define DTPB_PWM_OE_BIT 7
`define DTPB_BUZZ_EN_BIT 7
`define DTPB_BUZZ_SRC_BIT 3

`define DTPB_RST_POWER_CTRL 8'h00
`define DTPB_RST_UP_MODE 8'h08
`define DTPB_RST_BYTE 8'h00
`define DTPB_ALL_ONES 8'hFF
`define DTPB_ZERO 8'h00

`endif

// >>> rtl/dtpb_top.v
// Dual timer block: 8-bit up timer with shared prescaler, 8-bit reloadable
// down timer with its own prescaler, PWM and buzzer on one shared pin.
// Assumes clk is the instruction clock; pin and low RC inputs are asynchronous.
`timescale 1ns/1ps
`include "dtpb_defs.vh"

//////////////////////////////////////////////////////////////////////////////
// Operation
// - Up timer is 8-bit incrementing counter, counts only while its enable is set
// - Writing up timer loads new start value; reading returns present count
// - Up timer clock: instruction clock, external pin, or low RC clock
// - Edge select picks falling or rising edges of pin or low RC clock
// - Shared prescaler divides up timer when assigned; writing assign 0 clears it
// - Shared prescaler ratio is 3-bit field from 1:2 to 1:256
// - Selected clock synchronised by default; async option bypasses alignment stage
// - Up timer overflow sets flag bit 0; cleared only by writing 0
// - Down timer write loads reload and counter; read returns present count
// - Down timer counts while enabled; source bit picks pin or instruction clock
// - Down timer edge bit picks falling or rising pin edges
// - Second prescaler enabled by active-low bit; ratio field; value readable
// - One-shot mode counts down once to zero then stops after underflow
// - Continuous mode reloads start value or wraps to 0xFF after underflow
// - Down timer underflow sets flag bit 3; cleared only by writing 0
// - PWM enable with pin configured for PWM drives shared pin as output
// - PWM polarity bit selects active-low when set, active-high when clear
// - Duty gives active ticks per frame; zero never active; frame from start value
// - Buzzer enable with pin configured for buzzer drives shared pin as output unless PWM is driving it
// - Buzzer source is prescaler or timer output; ratio from 1:2 to 1:256
// - Shared pin is external clock input for either timer when selected
// - Global enable gates both interrupt requests; set and cleared by instructions
module dtpb_top (
    input wire clk,
    input wire rstn,
    input wire [`DTPB_AW-1:0] addr,
    input wire [`DTPB_DW-1:0] wdata,
    input wire wr,
    input wire rd,
    output reg [`DTPB_DW-1:0] rdata,
    input wire gie_set,
    input wire gie_clear,
    input wire cfg_async,
    input wire cfg_pin_pwm,
    input wire cfg_pin_buzzer,
    input wire shared_output_pin_in,
    input wire low_rc_clock,
    output reg shared_output_pin_out,
    output reg shared_output_pin_oe,
    output reg irq_request
);

    // Ratio 1:2^(sel+1): prescaler fires when its low sel+1 bits are all ones
    function [7:0] dtpb_ratio_mask;
        input [2:0] sel;
        begin
            dtpb_ratio_mask = (8'h02 << sel) - 8'h01;
        end
    endfunction

    //////////////////////////////////////////////////////////////////////////
    // Registers seen by software

    reg [7:0] power_control_one;
    reg [7:0] up_timer_mode_reg;
    reg [7:0] up_count;
    reg [7:0] interrupt_enable_reg;
    reg [1:0] irq_flags;
    reg [7:0] down_timer_control_one;
    reg [7:0] down_timer_control_two;
    reg [7:0] down_timer_reload_reg;
    reg [7:0] down_count;
    reg [7:0] pwm_duty_reg;
    reg [7:0] buzzer_control_reg;
    reg [7:0] ps0_count;
    reg [7:0] ps1_count;
    reg [7:0] buzz_count;
    reg down_stopped;

    wire up_timer_enable = power_control_one[`DTPB_UP_EN_BIT];
    wire global_irq_enable = power_control_one[`DTPB_GIE_BIT];
    wire up_timer_low_clock_select = up_timer_mode_reg[`DTPB_LOWCLK_BIT];
    wire up_timer_source_select = up_timer_mode_reg[`DTPB_SRC_BIT];
    wire up_timer_edge_select = up_timer_mode_reg[`DTPB_EDGE_BIT];
    wire prescaler_assign = up_timer_mode_reg[`DTPB_PSA_BIT];
    wire [2:0] shared_prescaler_ratio = up_timer_mode_reg[`DTPB_RATIO_MSB:0];
    wire down_timer_enable = down_timer_control_one[`DTPB_DN_EN_BIT];
    wire reload_select = down_timer_control_one[`DTPB_RELOAD_BIT];
    wire one_shot_select = down_timer_control_one[`DTPB_ONESHOT_BIT];
    wire pwm_active_low = down_timer_control_one[`DTPB_PWM_AL_BIT];
    wire pwm_output_enable = down_timer_control_one[`DTPB_PWM_OE_BIT];
    wire down_timer_source_select = down_timer_control_two[`DTPB_SRC_BIT];
    wire down_timer_edge_select = down_timer_control_two[`DTPB_EDGE_BIT];
    wire second_prescaler_enable_n = down_timer_control_two[`DTPB_SECOND_PRESCALER_ENABLE_N_N_BIT];
    wire [2:0] second_prescaler_ratio = down_timer_control_two[`DTPB_RATIO_MSB:0];
    wire buzzer_enable = buzzer_control_reg[`DTPB_BUZZ_EN_BIT];
    wire buzzer_source = buzzer_control_reg[`DTPB_BUZZ_SRC_BIT];
    wire [2:0] buzzer_ratio = buzzer_control_reg[`DTPB_RATIO_MSB:0];

    wire wr_power = wr && (addr == `DTPB_ADDR_POWER_CTRL);
    wire wr_up_mode = wr && (addr == `DTPB_ADDR_UP_MODE);
    wire wr_up_count = wr && (addr == `DTPB_ADDR_UP_COUNT);
    wire wr_irq_en = wr && (addr == `DTPB_ADDR_IRQ_ENABLE);
    wire wr_irq_flag = wr && (addr == `DTPB_ADDR_IRQ_FLAG);
    wire wr_dn_one = wr && (addr == `DTPB_ADDR_DN_CTRL_ONE);
    wire wr_dn_two = wr && (addr == `DTPB_ADDR_DN_CTRL_TWO);
    wire wr_dn_count = wr && (addr == `DTPB_ADDR_DN_COUNT);
    wire wr_duty = wr && (addr == `DTPB_ADDR_PWM_DUTY);
    wire wr_buzz = wr && (addr == `DTPB_ADDR_BUZZ_CTRL);

    //////////////////////////////////////////////////////////////////////////
    // Input synchronisers and edge detection

    reg pin_meta;
    reg pin_sync;
    reg pin_prev;
    reg lrc_meta;
    reg lrc_sync;
    reg lrc_prev;
    reg up_edge_aligned;

    always @(posedge clk) begin
        if (!rstn) begin
            pin_meta <= 1'b0;
            pin_sync <= 1'b0;
            pin_prev <= 1'b0;
            lrc_meta <= 1'b0;
            lrc_sync <= 1'b0;
            lrc_prev <= 1'b0;
        end else begin
            pin_meta <= shared_output_pin_in;
            pin_sync <= pin_meta;
            pin_prev <= pin_sync;
            lrc_meta <= low_rc_clock;
            lrc_sync <= lrc_meta;
            lrc_prev <= lrc_sync;
        end
    end

    wire pin_rise = pin_sync && !pin_prev;
    wire pin_fall = !pin_sync && pin_prev;
    wire lrc_rise = lrc_sync && !lrc_prev;
    wire lrc_fall = !lrc_sync && lrc_prev;

    // Up timer source and edge choice
    wire up_ext_edge = up_timer_low_clock_select ?
        (up_timer_edge_select ? lrc_fall : lrc_rise) :
        (up_timer_edge_select ? pin_fall : pin_rise);

    // Default mode adds one alignment stage; async mode trades it for latency
    always @(posedge clk) begin
        if (!rstn) begin
            up_edge_aligned <= 1'b0;
        end else begin
            up_edge_aligned <= up_ext_edge;
        end
    end

    wire up_ext_tick = cfg_async ? up_ext_edge : up_edge_aligned;
    wire up_src_tick = up_timer_source_select ? up_ext_tick : 1'b1;

    wire dn_src_tick = down_timer_source_select ?
        (down_timer_edge_select ? pin_fall : pin_rise) : 1'b1;

    //////////////////////////////////////////////////////////////////////////
    // Prescalers

    wire [7:0] ps0_mask = dtpb_ratio_mask(shared_prescaler_ratio);
    wire [7:0] ps1_mask = dtpb_ratio_mask(second_prescaler_ratio);
    wire ps0_active = up_timer_enable && !prescaler_assign;
    wire ps0_out = up_src_tick && ((ps0_count & ps0_mask) == ps0_mask);
    wire ps1_active = down_timer_enable && !down_stopped;
    wire ps1_out = dn_src_tick && ((ps1_count & ps1_mask) == ps1_mask);

    always @(posedge clk) begin
        if (!rstn) begin
            ps0_count <= `DTPB_ZERO;
        end else if (wr_up_mode && !wdata[`DTPB_PSA_BIT]) begin
            ps0_count <= `DTPB_ZERO;
        end else if (ps0_active && up_src_tick) begin
            ps0_count <= ps0_out ? `DTPB_ZERO : ps0_count + 8'h01;
        end
    end

    always @(posedge clk) begin
        if (!rstn) begin
            ps1_count <= `DTPB_ZERO;
        end else if (ps1_active && dn_src_tick) begin
            ps1_count <= ps1_out ? `DTPB_ZERO : ps1_count + 8'h01;
        end
    end

    wire up_tick = up_timer_enable &&
        (prescaler_assign ? up_src_tick : ps0_out);
    wire dn_tick = ps1_active &&
        (second_prescaler_enable_n ? dn_src_tick : ps1_out);

    //////////////////////////////////////////////////////////////////////////
    // Up timer

    wire up_overflow = up_tick && (up_count == `DTPB_ALL_ONES) && !wr_up_count;

    always @(posedge clk) begin
        if (!rstn) begin
            up_count <= `DTPB_RST_BYTE;
        end else if (wr_up_count) begin
            up_count <= wdata;
        end else if (up_tick) begin
            up_count <= up_count + 8'h01;
        end
    end

    //////////////////////////////////////////////////////////////////////////
    // Down timer

    wire dn_underflow = dn_tick && (down_count == `DTPB_ZERO) && !wr_dn_count;

    always @(posedge clk) begin
        if (!rstn) begin
            down_count <= `DTPB_RST_BYTE;
            down_timer_reload_reg <= `DTPB_RST_BYTE;
            down_stopped <= 1'b0;
        end else if (wr_dn_count) begin
            down_count <= wdata;
            down_timer_reload_reg <= wdata;
            down_stopped <= 1'b0;
        end else begin
            if (wr_dn_one && wdata[`DTPB_DN_EN_BIT] && !down_timer_enable) begin
                down_stopped <= 1'b0;
            end
            if (dn_underflow) begin
                if (one_shot_select) begin
                    down_stopped <= 1'b1;
                end else if (reload_select) begin
                    down_count <= down_timer_reload_reg;
                end else begin
                    down_count <= `DTPB_ALL_ONES;
                end
            end else if (dn_tick) begin
                down_count <= down_count - 8'h01;
            end
        end
    end

    //////////////////////////////////////////////////////////////////////////
    // Buzzer divider: bit n of a pulse counter toggles every 2^n pulses

    wire buzz_pulse = buzzer_source ? dn_underflow : (ps1_active && ps1_out);

    always @(posedge clk) begin
        if (!rstn) begin
            buzz_count <= `DTPB_ZERO;
        end else if (!buzzer_enable) begin
            buzz_count <= `DTPB_ZERO;
        end else if (buzz_pulse) begin
            buzz_count <= buzz_count + 8'h01;
        end
    end

    wire buzz_level = buzz_count[buzzer_ratio];

    // Count below duty: duty ticks of each frame of start value plus one
    wire pwm_level = (down_count < pwm_duty_reg) ^ pwm_active_low;

    //////////////////////////////////////////////////////////////////////////
    // Control registers and flags

    always @(posedge clk) begin
        if (!rstn) begin
            power_control_one <= `DTPB_RST_POWER_CTRL;
            up_timer_mode_reg <= `DTPB_RST_UP_MODE;
            interrupt_enable_reg <= `DTPB_RST_BYTE;
            down_timer_control_one <= `DTPB_RST_BYTE;
            down_timer_control_two <= `DTPB_RST_BYTE;
            pwm_duty_reg <= `DTPB_RST_BYTE;
            buzzer_control_reg <= `DTPB_RST_BYTE;
        end else begin
            if (wr_power) begin
                power_control_one <= wdata;
            end else if (gie_set) begin
                power_control_one[`DTPB_GIE_BIT] <= 1'b1;
            end else if (gie_clear) begin
                power_control_one[`DTPB_GIE_BIT] <= 1'b0;
            end
            if (wr_up_mode) begin
                up_timer_mode_reg <= wdata;
            end
            if (wr_irq_en) begin
                interrupt_enable_reg <= wdata;
            end
            if (wr_dn_one) begin
                down_timer_control_one <= wdata;
            end
            if (wr_dn_two) begin
                down_timer_control_two <= wdata;
            end
            if (wr_duty) begin
                pwm_duty_reg <= wdata;
            end
            if (wr_buzz) begin
                buzzer_control_reg <= wdata;
            end
        end
    end

    // A hardware set in the clearing cycle wins over the software clear
    always @(posedge clk) begin
        if (!rstn) begin
            irq_flags <= 2'b00;
        end else begin
            irq_flags[0] <= up_overflow ||
                (irq_flags[0] && !(wr_irq_flag && !wdata[`DTPB_UP_IRQ_BIT]));
            irq_flags[1] <= dn_underflow ||
                (irq_flags[1] && !(wr_irq_flag && !wdata[`DTPB_DN_IRQ_BIT]));
        end
    end

    //////////////////////////////////////////////////////////////////////////
    // Outputs and read port

    always @(posedge clk) begin
        if (!rstn) begin
            irq_request <= 1'b0;
            shared_output_pin_out <= 1'b0;
            shared_output_pin_oe <= 1'b0;
        end else begin
            irq_request <= global_irq_enable &&
                ((irq_flags[0] && interrupt_enable_reg[`DTPB_UP_IRQ_BIT]) ||
                 (irq_flags[1] && interrupt_enable_reg[`DTPB_DN_IRQ_BIT]));
            if (pwm_output_enable && cfg_pin_pwm) begin
                shared_output_pin_out <= pwm_level;
                shared_output_pin_oe <= 1'b1;
            end else if (buzzer_enable && cfg_pin_buzzer) begin
                shared_output_pin_out <= buzz_level;
                shared_output_pin_oe <= 1'b1;
            end else begin
                shared_output_pin_out <= 1'b0;
                shared_output_pin_oe <= 1'b0;
            end
        end
    end

    always @(posedge clk) begin
        if (!rstn) begin
            rdata <= `DTPB_ZERO;
        end else if (rd) begin
            case (addr)
                `DTPB_ADDR_POWER_CTRL: rdata <= power_control_one;
                `DTPB_ADDR_UP_MODE: rdata <= up_timer_mode_reg;
                `DTPB_ADDR_UP_COUNT: rdata <= up_count;
                `DTPB_ADDR_IRQ_ENABLE: rdata <= interrupt_enable_reg;
                `DTPB_ADDR_IRQ_FLAG: rdata <= {4'h0, irq_flags[1], 2'b00, irq_flags[0]};
                `DTPB_ADDR_DN_CTRL_ONE: rdata <= down_timer_control_one;
                `DTPB_ADDR_DN_CTRL_TWO: rdata <= down_timer_control_two;
                `DTPB_ADDR_DN_COUNT: rdata <= down_count;
                `DTPB_ADDR_PS1_VALUE: rdata <= ps1_count;
                `DTPB_ADDR_PWM_DUTY: rdata <= pwm_duty_reg;
                `DTPB_ADDR_BUZZ_CTRL: rdata <= buzzer_control_reg;
                default: rdata <= `DTPB_ZERO;
            endcase
        end else begin
            rdata <= `DTPB_ZERO;
        end
    end

endmodule

// >>> sim/dtpb_props.sv
// Port-level checker for the dual timer block.
// Assumes one clock domain and a synchronous active-low reset.
`timescale 1ns/1ps
module dtpb_props (
    input wire clk,
    input wire rstn,
    input wire [3:0] addr,
    input wire [7:0] wdata,
    input wire wr,
    input wire rd,
    input wire [7:0] rdata,
    input wire gie_set,
    input wire gie_clear,
    input wire cfg_pin_pwm,
    input wire cfg_pin_buzzer,
    input wire shared_output_pin_out,
    input wire shared_output_pin_oe,
    input wire irq_request
);
    reg gie_m;
    reg [7:0] ie_m;
    reg [7:0] duty_m;
    //////////////////////////////////////////////////////////////////////////
    // Shadows of software state; a register write beats the pulses, set beats clear
    always @(posedge clk) begin
        if (!rstn) begin
            gie_m <= 1'b0;
            ie_m <= 8'h00;
            duty_m <= 8'h00;
        end else begin
            if (wr && addr == 4'h0) gie_m <= wdata[7];
            else if (gie_set) gie_m <= 1'b1;
            else if (gie_clear) gie_m <= 1'b0;
            if (wr && addr == 4'h3) ie_m <= wdata;
            if (wr && addr == 4'h9) duty_m <= wdata;
        end
    end
    //////////////////////////////////////////////////////////////////////////
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rstn);
    sequence s_gie_drop;
        gie_clear && !gie_set;
    endsequence
    property p_rd_idle;
        !rd |=> rdata == 8'h00;
    endproperty
    a_rd_idle: assert property (p_rd_idle) else $error("read data not idle");
    property p_unmapped;
        rd && addr > 4'hA |=> rdata == 8'h00;
    endproperty
    a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
    property p_duty_rb;
        rd && addr == 4'h9 |=> rdata == $past(duty_m);
    endproperty
    a_duty_rb: assert property (p_duty_rb) else $error("duty readback wrong");
    property p_oe_cfg;
        shared_output_pin_oe |-> $past(cfg_pin_pwm || cfg_pin_buzzer);
    endproperty
    a_oe_cfg: assert property (p_oe_cfg) else $error("pin driven unconfigured");
    property p_out_idle;
        !shared_output_pin_oe |-> !shared_output_pin_out;
    endproperty
    a_out_idle: assert property (p_out_idle) else $error("pin value while idle");
    property p_irq_gie;
        irq_request |-> $past(gie_m);
    endproperty
    a_irq_gie: assert property (p_irq_gie) else $error("request without gie");
    property p_irq_en;
        irq_request |-> $past(ie_m[0] || ie_m[3]);
    endproperty
    a_irq_en: assert property (p_irq_en) else $error("request while masked");
    property p_gie_off;
        s_gie_drop |-> ##2 !irq_request;
    endproperty
    a_gie_off: assert property (p_gie_off) else $error("request after gie off");
    c_irq: cover property ($rose(irq_request));
    c_pwm: cover property (shared_output_pin_oe && cfg_pin_pwm);
    c_buzz: cover property (shared_output_pin_oe && cfg_pin_buzzer && !cfg_pin_pwm);
endmodule

// >>> sim/dtpb_tb.sv
// Self-checking bench for the dual timer block with random stimulus.
// Assumes the register map of the block header; pins are driven directly.
`timescale 1ns/1ps
`define CHK(g, x) begin checked = checked + 1; if ((g) !== (x)) begin \
    miscompares = miscompares + 1; \
    $display("MISMATCH %0t got %0h exp %0h", $time, g, x); end end
module testbench;
    reg clk, rstn, wr, rd, gie_set, gie_clear, cfg_async, cfg_pin_pwm, cfg_pin_buzzer;
    reg ext_pin, lrc, last;
    reg [3:0] addr;
    reg [7:0] wdata, v, d, c1, e;
    reg [8:0] r9;
    reg [31:0] lfsr_q;
    wire [7:0] rdata;
    wire pin_out, pin_oe, irq;
    integer miscompares, checked, i, j, n;
    integer cyc = 0;
    dtpb_top uut (.clk(clk), .rstn(rstn), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
        .rdata(rdata), .gie_set(gie_set), .gie_clear(gie_clear), .cfg_async(cfg_async),
        .cfg_pin_pwm(cfg_pin_pwm), .cfg_pin_buzzer(cfg_pin_buzzer),
        .shared_output_pin_in(ext_pin), .low_rc_clock(lrc), .shared_output_pin_out(pin_out),
        .shared_output_pin_oe(pin_oe), .irq_request(irq));
    //////////////////////////////////////////////////////////////////////////
    function [31:0] lfsr_next(input [31:0] s);
        lfsr_next = {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    // Reference down counter; one-shot parks at zero after its underflow
    function [8:0] dn_exp(input [7:0] init, input integer t, input [7:0] ctl);
        reg [7:0] c;
        reg uf, stop;
        integer k;
        begin
            c = init;
            uf = 1'b0;
            stop = 1'b0;
            for (k = 0; k < t; k = k + 1) begin
                if (!stop && c == 8'h00) begin
                    uf = 1'b1;
                    stop = ctl[2];
                    c = ctl[2] ? 8'h00 : (ctl[1] ? init : 8'hFF);
                end else if (!stop) begin
                    c = c - 8'h01;
                end
            end
            dn_exp = {uf, c};
        end
    endfunction
    task wr_r(input [3:0] a, input [7:0] x);
        @(posedge clk);
        addr <= a;
        wdata <= x;
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
    endtask
    task rd_r(input [3:0] a, output [7:0] x);
        @(posedge clk);
        addr <= a;
        rd <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        #1 x = rdata;
    endtask
    task cyc_w(input integer k);
        repeat (k) @(posedge clk);
    endtask
    task gie_pulse(input s);
        @(posedge clk);
        gie_set <= s;
        gie_clear <= !s;
        @(posedge clk);
        gie_set <= 1'b0;
        gie_clear <= 1'b0;
    endtask
    // Seven toggles from low: four rising and three falling edges, ends high
    task edges(input use_lrc);
        integer p;
        for (p = 0; p < 7; p = p + 1) begin
            @(posedge clk);
            if (use_lrc) lrc <= ~lrc;
            else ext_pin <= ~ext_pin;
            cyc_w(3); // Four cycles per toggle
        end
    endtask
    task report_and_stop;
        if (miscompares == 0 && checked > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask
    //////////////////////////////////////////////////////////////////////////
    initial begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 40000) begin
            miscompares = miscompares + 1;
            report_and_stop;
        end
    end
    initial begin
        {rstn, wr, rd, gie_set, gie_clear, cfg_async, cfg_pin_pwm, cfg_pin_buzzer} = 8'h00;
        {ext_pin, lrc, addr, wdata} = 14'h0000;
        miscompares = 0;
        checked = 0;
        lfsr_q = 32'h00015002;
        cyc_w(8);
        rstn <= 1'b1;
        cyc_w(1);
        for (i = 0; i < 16; i = i + 1) begin
            rd_r(i[3:0], v);
            `CHK(v, (i == 1) ? 8'h08 : 8'h00) // Reset value
        end
        lfsr_q = lfsr_next(lfsr_q);
        wr_r(4'h9, lfsr_q[7:0]);
        rd_r(4'h9, v);
        `CHK(v, lfsr_q[7:0]) // Duty
        wr_r(4'h3, 8'h09);
        for (j = 0; j < 4; j = j + 1) begin
            lfsr_q = lfsr_next(lfsr_q);
            d = (j == 0) ? 8'hFE : lfsr_q[7:0];
            n = lfsr_q[11:8];
            e = d + n + 2;
            wr_r(4'h4, 8'h00);
            wr_r(4'h2, d);
            wr_r(4'h0, 8'h01);
            cyc_w(n);
            wr_r(4'h0, 8'h00);
            rd_r(4'h2, v);
            `CHK(v, e) // Count
            rd_r(4'h4, v);
            `CHK(v[0], (d + n > 253)) // Overflow
        end
        wr_r(4'h2, 8'hFF);
        wr_r(4'h0, 8'h01);
        wr_r(4'h0, 8'h00);
        gie_pulse(1'b1);
        wr_r(4'h4, 8'hFF);
        cyc_w(2);
        #1 `CHK(irq, 1'b1) // Request
        wr_r(4'h3, 8'h08);
        cyc_w(2);
        #1 `CHK(irq, 1'b0) // Masked
        wr_r(4'h3, 8'h09);
        gie_pulse(1'b0);
        cyc_w(2);
        #1 `CHK(irq, 1'b0) // Gated
        for (j = 0; j < 3; j = j + 1) begin
            wr_r(4'h2, 8'h00);
            wr_r(4'h1, j[7:0]);
            wr_r(4'h0, 8'h01);
            cyc_w((2 << j) * 4 - 2);
            wr_r(4'h0, 8'h00);
            rd_r(4'h2, v);
            `CHK(v, 8'h04) // Prescaled
        end
        for (j = 0; j < 4; j = j + 1) begin
            cfg_async <= (j == 3);
            wr_r(4'h2, 8'h00);
            wr_r(4'h1, 8'h28 | (j[0] ? 8'h10 : 8'h00) | (j[1] ? 8'h80 : 8'h00));
            wr_r(4'h0, 8'h01);
            edges(j[1]);
            cyc_w(6);
            wr_r(4'h0, 8'h00);
            rd_r(4'h2, v);
            `CHK(v, j[0] ? 8'h03 : 8'h04) // Source and edge
            {ext_pin, lrc} <= 2'b00;
        end
        cfg_async <= 1'b0;
        wr_r(4'h1, 8'h08);
        wr_r(4'h6, 8'h28);
        wr_r(4'h7, 8'h10);
        wr_r(4'h5, 8'h01);
        edges(1'b0);
        cyc_w(6);
        wr_r(4'h5, 8'h00);
        rd_r(4'h7, v);
        `CHK(v, 8'h0C) // Pin clock
        ext_pin <= 1'b0;
        wr_r(4'h6, 8'h08);
        for (j = 0; j < 6; j = j + 1) begin
            lfsr_q = lfsr_next(lfsr_q);
            c1 = (j % 3 == 0) ? 8'h05 : ((j % 3 == 1) ? 8'h03 : 8'h01);
            d = {4'h0, lfsr_q[3:0]};
            n = lfsr_q[9:4];
            wr_r(4'h4, 8'h00);
            wr_r(4'h7, d);
            wr_r(4'h5, c1);
            cyc_w(n);
            wr_r(4'h5, 8'h00);
            r9 = dn_exp(d, n + 2, c1);
            rd_r(4'h7, v);
            `CHK(v, r9[7:0]) // Mode
            rd_r(4'h4, v);
            `CHK(v[3], r9[8]) // Underflow
        end
        cfg_pin_pwm <= 1'b1;
        wr_r(4'h7, 8'h07);
        for (j = 0; j < 4; j = j + 1) begin
            lfsr_q = lfsr_next(lfsr_q);
            d = (j == 0) ? 8'h00 : ((j == 1) ? 8'h07 : {5'h00, lfsr_q[2:0]});
            wr_r(4'h9, d); // Duty not above start value
            wr_r(4'h5, j[0] ? 8'hC3 : 8'h83);
            cyc_w(20);
            n = 0;
            repeat (32) begin
                @(posedge clk);
                n = n + pin_out;
            end
            `CHK(n, j[0] ? 32 - 4 * d : 4 * d) // Duty and polarity
            `CHK(pin_oe, 1'b1) // Driven
            wr_r(4'h5, 8'h00);
        end
        cfg_pin_pwm <= 1'b0;
        cfg_pin_buzzer <= 1'b1;
        wr_r(4'h6, 8'h00);
        wr_r(4'h5, 8'h01);
        for (j = 0; j < 3; j = j + 1) begin
            wr_r(4'hA, 8'h80 | j[7:0]);
            cyc_w(8);
            n = 0;
            last = pin_out;
            repeat (128) begin
                @(posedge clk);
                if (pin_out !== last) n = n + 1;
                last = pin_out;
            end
            `CHK(n >= (64 >> j) - 1 && n <= (64 >> j) + 1, 1'b1) // Rate
            `CHK(pin_oe, 1'b1) // Driven
        end
        wr_r(4'hA, 8'h00);
        cyc_w(3);
        #1 `CHK(pin_oe, 1'b0) // Released
        report_and_stop;
    end
endmodule
bind dtpb_top dtpb_props u_props (.clk(clk), .rstn(rstn), .addr(addr), .wdata(wdata),
    .wr(wr), .rd(rd), .rdata(rdata), .gie_set(gie_set), .gie_clear(gie_clear),
    .cfg_pin_pwm(cfg_pin_pwm), .cfg_pin_buzzer(cfg_pin_buzzer),
    .shared_output_pin_out(shared_output_pin_out),
    .shared_output_pin_oe(shared_output_pin_oe), .irq_request(irq_request));
